// ==== core/twm_master.sv ====
// two-wire master transmitter: registers, byte sequencer and bus monitor
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "twm_defs.svh"

// Functional notes
// - Four modes exist; software chooses which are permitted via permit bits.
// - A requested START waits until the bus is seen free.
// - After START is sent, flag rises with status 0x08.
// - Direction bit of the address selects transmit or receive mode.
// - After address and acknowledge slot, flag rises with 0x18, 0x20 or 0x38.
// - Data writes land only while flag is high; else discarded, collision set.
// - While the flag is high the bus transfer stays suspended.
// - Writing one to the flag bit clears it and lets the step proceed.
// - After a data byte and acknowledge slot, flag rises with matching status.
// - Read bit and not-acknowledge high; write and acknowledge low; 8-bit bytes.
// - A repeated START reports 0x10 and may address any slave.
// - STOP is sent, stop bit self-clears; start plus stop sends STOP then START.
// - Lost arbitration reports 0x38, releases bus; pending start retries when free.
module twm_master
   import twm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdata,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOeN,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN
);
   twm_state_t state_r;
   twm_state_t stateNxt;
   twm_op_t cmdOp_r;
   twm_op_t opNxt;
   logic cmdValid_r;
   logic cmdBit_r;
   logic issue;
   logic bitNxt;
   logic setFlag;
   logic stopClr;
   logic [7:0] codeNxt;
   logic flag_r;
   logic ackEn_r;
   logic start_r;
   logic stop_r;
   logic wcol_r;
   logic en_r;
   logic ie_r;
   logic [1:0] presc_r;
   logic [7:0] code_r;
   logic [7:0] data_r;
   logic [7:0] shift_r;
   logic [2:0] bitCnt_r;
   logic [3:0] permit_r;
   logic own_r;
   logic addrPhase_r;
   logic readMode_r;
   logic busBusy_r;
   logic sdaPrev_r;
   logic pinLow_r;
   logic [7:0] rdata_r;
   logic [1:0] pinIn;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic engDone;
   logic engRx;
   logic engArb;
   logic wrCtrl;
   logic wrData;
   logic masterOk;
   logic startSeen;
   logic stopSeen;

   assign pinIn = {sdaIn, sclIn};
   assign wrCtrl = regWr && regAddr == `TWM_ADDR_CTRL;
   assign wrData = regWr && regAddr == `TWM_ADDR_DATA;
   assign masterOk = permit_r[`TWM_PM_MT] | permit_r[`TWM_PM_MR];
   assign startSeen = sync2_r[0] && sdaPrev_r && !sync2_r[1];
   assign stopSeen = sync2_r[0] && !sdaPrev_r && sync2_r[1];
   assign regRdata = rdata_r;
   assign sclOut = pinLow_r;
   assign sdaOut = pinLow_r;

   // two-stage synchronisers for both bus lines
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               sync1_r[g] <= 1'b1;
               sync2_r[g] <= 1'b1;
            end else begin
               sync1_r[g] <= pinIn[g];
               sync2_r[g] <= sync1_r[g];
            end
         end
      end
   endgenerate

   // bus monitor: busy from a seen START to a seen STOP
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sdaPrev_r <= 1'b1;
         busBusy_r <= 1'b0;
         pinLow_r <= 1'b0;
      end else begin
         sdaPrev_r <= sync2_r[1];
         pinLow_r <= 1'b0;
         if (startSeen) begin
            busBusy_r <= 1'b1;
         end else if (stopSeen) begin
            busBusy_r <= 1'b0;
         end
      end
   end

   // control bits written by software
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ackEn_r <= 1'b0;
         start_r <= 1'b0;
         stop_r <= 1'b0;
         en_r <= 1'b0;
         ie_r <= 1'b0;
      end else begin
         if (wrCtrl) begin
            ackEn_r <= regWdata[`TWM_CB_ACKEN];
            start_r <= regWdata[`TWM_CB_START];
            en_r <= regWdata[`TWM_CB_EN];
            ie_r <= regWdata[`TWM_CB_IE];
         end
         if (wrCtrl) begin
            stop_r <= regWdata[`TWM_CB_STOP];
         end else if (stopClr) begin
            stop_r <= 1'b0;
         end
      end
   end

   // step flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else if (!en_r) begin
         flag_r <= 1'b0;
      end else if (setFlag) begin
         flag_r <= 1'b1;
      end else if (wrCtrl && regWdata[`TWM_CB_FLAG]) begin
         flag_r <= 1'b0;
      end
   end

   // data register and write collision
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         data_r <= `TWM_RST_DATA;
         wcol_r <= 1'b0;
      end else if (wrData) begin
         wcol_r <= !flag_r;
         if (flag_r) begin
            data_r <= regWdata;
         end
      end
   end

   // status code, prescaler field and mode permits
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         code_r <= `TWM_ST_NONE;
         presc_r <= `TWM_RST_PRESC;
         permit_r <= `TWM_RST_PERMIT;
      end else begin
         code_r <= codeNxt;
         if (regWr && regAddr == `TWM_ADDR_STAT) begin
            presc_r <= regWdata[`TWM_PRESC];
         end
         if (regWr && regAddr == `TWM_ADDR_MODE) begin
            permit_r <= regWdata[`TWM_PERMIT];
         end
      end
   end

   // read port: data stand in the cycle after the strobe only
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            `TWM_ADDR_CTRL: rdata_r <= {flag_r, ackEn_r, start_r, stop_r, wcol_r, en_r, 1'b0, ie_r};
            `TWM_ADDR_STAT: rdata_r <= (code_r & `TWM_CODE_MASK) | {6'h00, presc_r};
            `TWM_ADDR_DATA: rdata_r <= data_r;
            default: rdata_r <= {permit_r, 1'b0, busBusy_r, readMode_r, own_r};
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // byte sequencer
   always_comb begin
      stateNxt = state_r;
      issue = 1'b0;
      opNxt = OP_BIT;
      bitNxt = 1'b1;
      setFlag = 1'b0;
      stopClr = 1'b0;
      codeNxt = code_r;
      case (state_r)
         ST_IDLE: begin
            if (start_r && masterOk && !flag_r) begin
               stateNxt = ST_WFREE;
            end
         end
         ST_WFREE: begin
            if (!busBusy_r) begin
               issue = 1'b1;
               opNxt = OP_START;
               stateNxt = ST_START;
            end
         end
         ST_START: begin
            if (engDone) begin
               setFlag = 1'b1;
               codeNxt = own_r ? `TWM_ST_RSTART : `TWM_ST_START;
               stateNxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!flag_r) begin
               if (!own_r) begin
                  stateNxt = start_r ? ST_WFREE : ST_IDLE;
               end else if (stop_r) begin
                  issue = 1'b1;
                  opNxt = OP_STOP;
                  stateNxt = ST_STOP;
               end else if (start_r) begin
                  issue = 1'b1;
                  opNxt = OP_START;
                  stateNxt = ST_START;
               end else begin
                  issue = 1'b1;
                  bitNxt = data_r[`TWM_MSB];
                  stateNxt = ST_SHIFT;
               end
            end
         end
         ST_SHIFT: begin
            if (engDone) begin
               if (engArb) begin
                  setFlag = 1'b1;
                  codeNxt = `TWM_ST_ARB;
                  stateNxt = ST_HOLD;
               end else if (bitCnt_r == 3'h0) begin
                  issue = 1'b1;
                  opNxt = OP_ACK;
                  stateNxt = ST_ACK;
               end else begin
                  issue = 1'b1;
                  bitNxt = shift_r[`TWM_MSB - 1];
               end
            end
         end
         ST_ACK: begin
            if (engDone) begin
               setFlag = 1'b1;
               stateNxt = ST_HOLD;
               if (addrPhase_r) begin
                  codeNxt = engRx ? `TWM_ST_ANACK : `TWM_ST_AACK;
               end else begin
                  codeNxt = engRx ? `TWM_ST_DNACK : `TWM_ST_DACK;
               end
            end
         end
         ST_STOP: begin
            if (engDone) begin
               stopClr = 1'b1;
               stateNxt = start_r ? ST_WFREE : ST_IDLE;
            end
         end
         default: stateNxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         cmdValid_r <= 1'b0;
         cmdOp_r <= OP_BIT;
         cmdBit_r <= 1'b1;
      end else if (!en_r) begin
         state_r <= ST_IDLE;
         cmdValid_r <= 1'b0;
      end else begin
         state_r <= stateNxt;
         cmdValid_r <= issue;
         cmdOp_r <= opNxt;
         cmdBit_r <= bitNxt;
      end
   end

   // shift register, bit count and bus ownership
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shift_r <= 8'h00;
         bitCnt_r <= 3'h0;
         own_r <= 1'b0;
         addrPhase_r <= 1'b0;
         readMode_r <= 1'b0;
      end else if (!en_r) begin
         own_r <= 1'b0;
         addrPhase_r <= 1'b0;
      end else begin
         if (state_r == ST_HOLD && stateNxt == ST_SHIFT) begin
            shift_r <= data_r;
            bitCnt_r <= `TWM_BIT_TOP;
         end else if (state_r == ST_SHIFT && engDone && !engArb) begin
            shift_r <= {shift_r[`TWM_MSB - 1:0], 1'b0};
            bitCnt_r <= bitCnt_r - 3'h1;
         end
         if (state_r == ST_START && engDone) begin
            own_r <= 1'b1;
            addrPhase_r <= 1'b1;
         end else if (state_r == ST_SHIFT && engDone && engArb) begin
            own_r <= 1'b0;
            addrPhase_r <= 1'b0;
         end else if (state_r == ST_STOP && engDone) begin
            own_r <= 1'b0;
         end else if (state_r == ST_ACK && engDone) begin
            addrPhase_r <= 1'b0;
         end
         if (state_r == ST_ACK && engDone && addrPhase_r) begin
            readMode_r <= data_r[`TWM_LSB];
         end
      end
   end

   twm_bit_engine u_engine (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .abort(!en_r),
      .cmdValid(cmdValid_r),
      .cmdOp(cmdOp_r),
      .cmdBit(cmdBit_r),
      .sclHigh(sync2_r[0]),
      .sdaHigh(sync2_r[1]),
      .done(engDone),
      .rxBit(engRx),
      .arbLost(engArb),
      .sclOeN(sclOeN),
      .sdaOeN(sdaOeN)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   a_start_bus_free: assert property (
      cmdValid_r && cmdOp_r == OP_START && !own_r |-> !$past(busBusy_r))
      else $error("start issued while bus busy");

   a_start_status: assert property (
      state_r == ST_START && engDone && !own_r |=> flag_r && code_r == `TWM_ST_START)
      else $error("start sent without flag and start code");

   a_rstart_status: assert property (
      state_r == ST_START && engDone && own_r |=> flag_r && code_r == `TWM_ST_RSTART)
      else $error("repeated start without its code");

   a_addr_status: assert property (
      state_r == ST_ACK && engDone && addrPhase_r
      |=> flag_r && code_r == ($past(engRx) ? `TWM_ST_ANACK : `TWM_ST_AACK))
      else $error("address answer code wrong");

   a_data_status: assert property (
      state_r == ST_ACK && engDone && !addrPhase_r
      |=> flag_r && code_r == ($past(engRx) ? `TWM_ST_DNACK : `TWM_ST_DACK))
      else $error("data answer code wrong");

   a_mode_select: assert property (
      state_r == ST_ACK && engDone && addrPhase_r |=> readMode_r == $past(data_r[`TWM_LSB]))
      else $error("direction bit not taken as mode");

   a_wcol_set: assert property (
      wrData && !flag_r |=> wcol_r && $stable(data_r))
      else $error("data write with flag low not discarded");

   a_wcol_clear: assert property (
      wrData && flag_r |=> !wcol_r && data_r == $past(regWdata))
      else $error("valid data write mishandled");

   a_flag_holds: assert property (
      flag_r |-> state_r == ST_HOLD && !cmdValid_r && !$past(cmdValid_r))
      else $error("bus activity while flag high");

   a_flag_clear: assert property (
      wrCtrl && regWdata[`TWM_CB_FLAG] && !setFlag |=> !flag_r)
      else $error("flag not cleared by writing one");

   a_stop_clear: assert property (
      state_r == ST_STOP && engDone && !wrCtrl |=> !stop_r)
      else $error("stop bit not cleared after stop");

   a_arb_release: assert property (
      state_r == ST_SHIFT && engDone && engArb
      |-> sclOeN && sdaOeN ##1 code_r == `TWM_ST_ARB && !own_r)
      else $error("lost arbitration not released");

   a_status_layout: assert property (
      regRd && regAddr == `TWM_ADDR_STAT
      |=> regRdata[2] == 1'b0 && (regRdata & `TWM_CODE_MASK) == $past(code_r))
      else $error("status layout wrong");
endmodule : twm_master

`default_nettype wire

// ==== core/twm_defs.svh ====
// register map, field positions, status codes and timing of the two-wire master
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

`define TWM_ADDR_CTRL 2'h0
`define TWM_ADDR_STAT 2'h1
`define TWM_ADDR_DATA 2'h2
`define TWM_ADDR_MODE 2'h3

`define TWM_CB_FLAG 7
`define TWM_CB_ACKEN 6
`define TWM_CB_START 5
`define TWM_CB_STOP 4
`define TWM_CB_EN 2
`define TWM_CB_IE 0

`define TWM_PRESC 1:0
`define TWM_PERMIT 7:4
`define TWM_PM_MT 0
`define TWM_PM_MR 1
`define TWM_MSB 7
`define TWM_LSB 0
`define TWM_CODE_MASK 8'hf8

`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AACK 8'h18
`define TWM_ST_ANACK 8'h20
`define TWM_ST_DACK 8'h28
`define TWM_ST_DNACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_NONE 8'hf8

`define TWM_RST_DATA 8'hff
`define TWM_RST_PERMIT 4'hf
`define TWM_RST_PRESC 2'h0
`define TWM_BIT_TOP 3'h7

`define TWM_CLK_NS 20
`define TWM_SCL_NS 160
`define TWM_QUARTER_CYC (`TWM_SCL_NS / (4 * `TWM_CLK_NS))

`endif

// ==== core/twm_pkg.sv ====
// shared types of the two-wire master
`default_nettype none

package twm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WFREE = 3'h1,
      ST_START = 3'h3,
      ST_SHIFT = 3'h2,
      ST_ACK = 3'h6,
      ST_HOLD = 3'h7,
      ST_STOP = 3'h5
   } twm_state_t;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_STOP = 2'h1,
      OP_BIT = 2'h2,
      OP_ACK = 2'h3
   } twm_op_t;
endpackage : twm_pkg

`default_nettype wire

// ==== core/twm_bit_engine.sv ====
// bit-level sequencer driving the two open-drain bus lines
`timescale 1ns/1ns
`default_nettype none
`include "twm_defs.svh"

module twm_bit_engine
   import twm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic abort,
   input wire logic cmdValid,
   input wire twm_op_t cmdOp,
   input wire logic cmdBit,
   input wire logic sclHigh,
   input wire logic sdaHigh,
   output logic done,
   output logic rxBit,
   output logic arbLost,
   output logic sclOeN,
   output logic sdaOeN
);
   twm_op_t op_r;
   twm_op_t curOp;
   logic bit_r;
   logic curBit;
   logic active_r;
   logic [1:0] phase_r;
   logic [1:0] ph;
   logic [3:0] timer_r;
   logic go;
   logic last;

   // four quarter phases per symbol; phase 1 waits for a stretched clock
   always_comb begin
      curOp = active_r ? op_r : cmdOp;
      curBit = active_r ? bit_r : cmdBit;
      last = active_r && timer_r == 4'h0 && phase_r == 2'h3;
      go = active_r ? (timer_r == 4'h0 && phase_r != 2'h3 && !(phase_r == 2'h1 && !sclHigh))
                    : cmdValid;
      ph = active_r ? phase_r + 2'h1 : 2'h0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         active_r <= 1'b0;
         op_r <= OP_BIT;
         bit_r <= 1'b1;
         phase_r <= 2'h0;
         timer_r <= 4'h0;
         done <= 1'b0;
      end else if (abort) begin
         active_r <= 1'b0;
         phase_r <= 2'h0;
         timer_r <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= last;
         if (last) begin
            active_r <= 1'b0;
         end else if (go) begin
            active_r <= 1'b1;
            op_r <= curOp;
            bit_r <= curBit;
            phase_r <= ph;
            timer_r <= 4'(`TWM_QUARTER_CYC - 1);
         end else if (timer_r != 4'h0) begin
            timer_r <= timer_r - 4'h1;
         end
      end
   end

   // line actions on entry to each phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sclOeN <= 1'b1;
         sdaOeN <= 1'b1;
         rxBit <= 1'b1;
         arbLost <= 1'b0;
      end else if (abort) begin
         sclOeN <= 1'b1;
         sdaOeN <= 1'b1;
      end else if (go) begin
         case (ph)
            2'h0: begin
               arbLost <= 1'b0;
               case (curOp)
                  OP_START: sdaOeN <= 1'b1;
                  OP_STOP: begin
                     sclOeN <= 1'b0;
                     sdaOeN <= 1'b0;
                  end
                  default: begin
                     sclOeN <= 1'b0;
                     sdaOeN <= curBit;
                  end
               endcase
            end
            2'h1: sclOeN <= 1'b1;
            2'h2: begin
               case (curOp)
                  OP_START: sdaOeN <= 1'b0;
                  OP_STOP: sdaOeN <= 1'b1;
                  default: begin
                     rxBit <= sdaHigh;
                     // an answer slot is listened to, never contested
                     arbLost <= curBit & !sdaHigh & (curOp == OP_BIT);
                  end
               endcase
            end
            default: begin
               if (curOp != OP_STOP) begin
                  sclOeN <= arbLost;
                  if (arbLost) begin
                     sdaOeN <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
endmodule : twm_bit_engine

`default_nettype wire

// ==== tb/twm_slave_model.sv ====
// slave receiver model on the two-wire bus
`timescale 1ns/1ns
`default_nettype none

module twm_slave_model (
   input wire logic clk_sys,
   input wire logic scl,
   input wire logic sda,
   input wire logic nackAll,
   output logic sdaOeN,
   output logic [7:0] lastByte,
   output logic [7:0] byteCnt
);
   logic prevScl = 1'h1;
   logic prevSda = 1'h1;
   logic [3:0] bitCnt = 4'h0;
   logic [7:0] shiftR = 8'h00;

   initial begin
      sdaOeN = 1'h1;
      lastByte = 8'h00;
      byteCnt = 8'h00;
   end

   // sampled on the system clock so a clock fall and a data change never race
   always @(posedge clk_sys) begin
      prevScl <= scl;
      prevSda <= sda;
      if (prevScl && scl && prevSda != sda) begin
         // start or stop: framing restarts
         bitCnt <= 4'h0;
         sdaOeN <= 1'h1;
      end else if (!prevScl && scl) begin
         if (bitCnt < 4'h8) begin
            shiftR <= {shiftR[6:0], sda};
         end
         if (bitCnt == 4'h7) begin
            lastByte <= {shiftR[6:0], sda};
            byteCnt <= byteCnt + 8'h01;
         end
         bitCnt <= bitCnt + 4'h1;
      end else if (prevScl && !scl) begin
         // acknowledge is a low level, a refusal leaves the line high
         sdaOeN <= !(bitCnt == 4'h8 && !nackAll);
         if (bitCnt == 4'h9) begin
            bitCnt <= 4'h0;
         end
      end
   end
endmodule : twm_slave_model

`default_nettype wire

// ==== tb/twm_master_bench.sv ====
// self-checking bench of the two-wire master transmitter
`timescale 1ns/1ns
`default_nettype none
`include "twm_defs.svh"

module twm_master_bench;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'h0;
   logic regRd = 1'h0;
   logic [7:0] regRdata;
   logic sclOut;
   logic sclOeN;
   logic sdaOut;
   logic sdaOeN;
   logic slvOeN;
   logic nackAll = 1'h0;
   logic clash = 1'h0;
   logic [7:0] lastByte;
   logic [7:0] byteCnt;
   wire logic sclWire;
   wire logic sdaWire;
   int err_total = 0;
   int checks = 0;

   // open-drain lines with pull-ups
   assign sclWire = sclOeN ? 1'b1 : sclOut;
   // clash stands for a second master holding the data line low
   assign sdaWire = (sdaOeN ? 1'b1 : sdaOut) & slvOeN & !clash;

   always #10 clk_sys = ~clk_sys;

   twm_master dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclWire),
      .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaWire), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN)
   );

   twm_slave_model slave (
      .clk_sys(clk_sys), .scl(sclWire), .sda(sdaWire), .nackAll(nackAll),
      .sdaOeN(slvOeN), .lastByte(lastByte), .byteCnt(byteCnt)
   );

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'h1;
      @(posedge clk_sys);
      regWr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk_sys);
      regRd <= 1'h0;
      #1;
      d = regRdata;
   endtask : rd

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      cmp(v & m, exp);
   endtask : chk

   // polls control until the bit under mask equals want
   task automatic waitBit(input logic [7:0] m, input logic [7:0] want);
      logic [7:0] v;
      v = ~want;
      for (int n = 0; n < 400 && (v & m) !== want; n++) begin
         rd(`TWM_ADDR_CTRL, v);
      end
      cmp(v & m, want);
   endtask : waitBit

   task automatic step(input logic [7:0] ctrl, input logic [7:0] code);
      wr(`TWM_ADDR_CTRL, ctrl);
      waitBit(8'h80, 8'h80);
      chk(`TWM_ADDR_STAT, `TWM_CODE_MASK, code);
   endtask : step

   task automatic testReset;
      chk(`TWM_ADDR_CTRL, 8'hff, 8'h00);
      chk(`TWM_ADDR_STAT, 8'hff, 8'hf8);
      chk(`TWM_ADDR_DATA, 8'hff, 8'hff);
      chk(`TWM_ADDR_MODE, 8'hff, 8'hf0);
      $display("test reset done");
   endtask : testReset

   task automatic testCollision;
      wr(`TWM_ADDR_DATA, 8'h55);
      chk(`TWM_ADDR_CTRL, 8'h08, 8'h08);
      chk(`TWM_ADDR_DATA, 8'hff, 8'hff);
      wr(`TWM_ADDR_STAT, 8'h03);
      chk(`TWM_ADDR_STAT, 8'hff, 8'hfb);
      wr(`TWM_ADDR_MODE, 8'h00);
      wr(`TWM_ADDR_CTRL, 8'ha4);
      repeat (40) @(posedge clk_sys);
      chk(`TWM_ADDR_MODE, 8'h05, 8'h00);
      wr(`TWM_ADDR_CTRL, 8'h00);
      wr(`TWM_ADDR_MODE, 8'hf0);
      $display("test collision done");
   endtask : testCollision

   task automatic testSend;
      step(8'ha4, `TWM_ST_START);
      repeat (200) @(posedge clk_sys);
      cmp(byteCnt, 8'h00);
      wr(`TWM_ADDR_DATA, 8'ha0);
      chk(`TWM_ADDR_CTRL, 8'h08, 8'h00);
      step(8'h84, `TWM_ST_AACK);
      cmp(lastByte, 8'ha0);
      wr(`TWM_ADDR_DATA, 8'h5a);
      step(8'h84, `TWM_ST_DACK);
      cmp(lastByte, 8'h5a);
      $display("test send done");
   endtask : testSend

   task automatic testNack;
      @(posedge clk_sys);
      nackAll <= 1'h1;
      wr(`TWM_ADDR_DATA, 8'h3c);
      step(8'h84, `TWM_ST_DNACK);
      step(8'ha4, `TWM_ST_RSTART);
      wr(`TWM_ADDR_DATA, 8'ha1);
      step(8'h84, `TWM_ST_ANACK);
      chk(`TWM_ADDR_MODE, 8'h02, 8'h02);
      @(posedge clk_sys);
      nackAll <= 1'h0;
      $display("test nack done");
   endtask : testNack

   task automatic testStop;
      wr(`TWM_ADDR_CTRL, 8'h94);
      waitBit(8'h10, 8'h00);
      repeat (20) @(posedge clk_sys);
      chk(`TWM_ADDR_MODE, 8'h05, 8'h00);
      step(8'ha4, `TWM_ST_START);
      wr(`TWM_ADDR_DATA, 8'ha0);
      step(8'h84, `TWM_ST_AACK);
      step(8'hb4, `TWM_ST_START);
      wr(`TWM_ADDR_CTRL, 8'h00);
      repeat (4) @(posedge clk_sys);
      cmp({6'h00, sclOeN, sdaOeN}, 8'h03);
      $display("test stop done");
   endtask : testStop

   task automatic testArb;
      step(8'ha4, `TWM_ST_START);
      @(posedge clk_sys);
      clash <= 1'h1;
      wr(`TWM_ADDR_DATA, 8'hff);
      step(8'h84, `TWM_ST_ARB);
      chk(`TWM_ADDR_MODE, 8'h05, 8'h04);
      cmp({6'h00, sclOeN, sdaOeN}, 8'h03);
      wr(`TWM_ADDR_CTRL, 8'ha4);
      repeat (20) @(posedge clk_sys);
      chk(`TWM_ADDR_CTRL, 8'h80, 8'h00);
      @(posedge clk_sys);
      clash <= 1'h0;
      waitBit(8'h80, 8'h80);
      chk(`TWM_ADDR_STAT, `TWM_CODE_MASK, `TWM_ST_START);
      $display("test arb done");
   endtask : testArb

   task automatic results;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'h0;
      testReset();
      testCollision();
      testSend();
      testNack();
      testStop();
      testArb();
      results();
   end

   initial begin
      #1500000;
      err_total++;
      results();
   end
endmodule : twm_master_bench

`default_nettype wire
